// ### dv/field_sensor_conditioning_tb_top.sv
/* Self-checking bench of the conditioning core: programmer model on the
   supply line, factory load, random samples, write-protect power cycle.
   Assumes the core's package constants and a 100 MHz clock. */
`timescale 1ns/10ps
module field_sensor_conditioning_tb_top;
    localparam int         BITC = 20;
    localparam logic [2:0] A0   = fsc_pkg::REG_GAIN_SHIFT;
    localparam logic [2:0] A1   = fsc_pkg::REG_RANGE_TC;
    localparam logic [2:0] A2   = fsc_pkg::REG_PROD_LOW;
    localparam logic [2:0] A4   = fsc_pkg::REG_MEASURED;
    logic              clk, sys_rst, adc_valid, adc_overflow;
    logic              overtemp_async, factory_wr, supply_program_line;
    logic signed [9:0] adc_sample;
    logic signed [7:0] temp_delta, gain_cfg, shift_cfg;
    logic        [1:0] factory_addr;
    logic       [15:0] factory_data;
    logic        [2:0] adc_range_q;
    logic        [9:0] dac_code_q;
    logic              diag_error_q, reply_bit_q, reply_active_q, align_cfg;
    logic        [7:0] rg, rs;
    logic       [15:0] words [4];
    logic       [15:0] cfg1;
    integer            seed;
    int                miscompares, tests_run;

    fsc_core #(.BIT_CYCLES(BITC)) fsc_core_i (
        .clk(clk), .sys_rst(sys_rst), .adc_sample(adc_sample),
        .adc_valid(adc_valid), .adc_overflow(adc_overflow),
        .temp_delta(temp_delta), .overtemp_async(overtemp_async),
        .adc_range_q(adc_range_q), .dac_code_q(dac_code_q),
        .diag_error_q(diag_error_q), .reply_bit_q(reply_bit_q),
        .supply_program_line(supply_program_line),
        .reply_active_q(reply_active_q), .factory_wr(factory_wr),
        .factory_addr(factory_addr), .factory_data(factory_data));

    fsc_programmer #(.BIT_CYCLES(BITC)) fsc_programmer_i (
        .clk(clk), .supply_program_line(supply_program_line),
        .reply_bit_q(reply_bit_q), .reply_active_q(reply_active_q));

    always #5 clk = ~clk;

    task automatic note(input logic ok, input logic [15:0] got, exp);
        tests_run++;
        if (!ok) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : note

    task automatic chk_reg(input logic [15:0] got, exp);
        note(got === exp, got, exp);
    endtask : chk_reg

    task automatic chk_out(input logic [10:0] got, exp);
        note(got === exp, {5'h00, got}, {5'h00, exp});
    endtask : chk_out

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    task automatic xfer(input logic wr, input logic [2:0] a,
                        input logic [15:0] d, input logic ack,
                        input logic [15:0] exp);
        fsc_programmer_i.transfer(wr, a, d);
        if (fsc_programmer_i.timed_out) begin
            miscompares++;
            print_verdict();
        end
        chk_reg({15'h0000, fsc_programmer_i.reply_q[16]}, {15'h0000, ack});
        chk_reg(fsc_programmer_i.reply_q[15:0], exp);
        // Line must idle a while before the next start bit
        repeat (BITC) @(posedge clk);
    endtask : xfer

    // Gain product of the shifted sample, before the temperature path
    function automatic int exp_prod(input logic signed [9:0] x);
        int se;
        se = align_cfg ? 4 * int'(shift_cfg) : int'(shift_cfg);
        return (int'(gain_cfg) * (int'(x) - se)) >>> 6;
    endfunction : exp_prod

    // Temperature gain factor, 1024 is unity
    function automatic int exp_tfac();
        int lin;
        int quad;
        int dt;
        lin  = int'($signed(cfg1[fsc_pkg::LIN_LSB +: 5]));
        quad = int'($signed(cfg1[fsc_pkg::QUAD_LSB +: 5]));
        dt   = int'(temp_delta);
        return 1024 + lin * dt + ((quad * dt * dt) >>> 8);
    endfunction : exp_tfac

    task automatic sample(input logic signed [9:0] x, input logic ovf);
        int          p;
        int          q;
        logic [10:0] e;
        p = exp_prod(x);
        // Negated so a positive gain rises for north fields
        q = -((p * exp_tfac()) >>> 10);
        e = {1'b0, 10'(q) ^ 10'h200};
        if (ovf || p > 511 || p < -512 || q > 511 || q < -512) e = 11'h400;
        @(posedge clk);
        #1 {adc_valid, adc_overflow, adc_sample} = {1'b1, ovf, x};
        @(posedge clk);
        #1 adc_valid = 1'b0;
        @(posedge clk);
        #1 chk_out({diag_error_q, dac_code_q}, e);
    endtask : sample

    task automatic set_cfg(input logic [7:0] g, s, input logic al,
                           input logic [2:0] r);
        logic [15:0] w1;
        w1 = {1'b0, al, 10'($random(seed)), 1'b0, r};
        {gain_cfg, shift_cfg, align_cfg} = {g, s, al};
        cfg1 = w1;
        xfer(1'b1, A0, {g, s}, 1'b1, {g, s});
        xfer(1'b1, A1, w1, 1'b1, w1);
        #1 chk_out({8'h00, adc_range_q}, {8'h00, r});
    endtask : set_cfg

    task automatic power_cycle();
        @(posedge clk);
        #1 sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 sys_rst = 1'b0;
        repeat (2) @(posedge clk);
    endtask : power_cycle

    initial begin
        {clk, sys_rst, adc_valid, adc_overflow, overtemp_async} = 5'h08;
        {factory_wr, factory_addr, factory_data} = 19'h00000;
        {adc_sample, temp_delta} = 18'h00000;
        {miscompares, tests_run} = '0;
        seed = 89444;
        words = '{16'h4000, 16'h0000, 16'($random(seed)), 16'($random(seed))};
        {gain_cfg, shift_cfg, align_cfg} = 17'h00000;
        cfg1 = 16'h0000;
        // Array powers up unknown: load it while reset still holds
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            #1 {factory_wr, factory_addr, factory_data} =
                {1'b1, 2'(i), words[i]};
            @(posedge clk);
            #1 factory_wr = 1'b0;
        end
        repeat (12) @(posedge clk);
        #1 sys_rst = 1'b0;
        power_cycle();
        for (int a = 0; a < 8; a++) begin
            rs = 8'(a);
            if (a != 4) begin
                xfer(1'b0, 3'(a), 16'h0000, 1'b1,
                     words[rs[1:0]] & {16{a < 4}});
            end
        end
        for (int a = 2; a < 5; a++) begin
            xfer(1'b1, 3'(a), 16'hA5A5, 1'b0, 16'hA5A5);
        end
        xfer(1'b0, A2, 16'h0000, 1'b1, words[2]);
        set_cfg(8'h40, 8'h00, 1'b0, 3'h0);
        sample(10'h1FF, 1'b0);
        sample(10'h200, 1'b0);
        sample(10'h000, 1'b1);
        sample(10'h39C, 1'b0);
        xfer(1'b0, A4, 16'h0000, 1'b1, 16'h0064);
        set_cfg(8'hC0, 8'hF0, 1'b1, 3'h7);
        sample(10'h064, 1'b0);
        sample(10'h000, 1'b0);
        xfer(1'b0, A4, 16'h0000, 1'b1, 16'h0040);
        for (int r = 0; r < 8; r++) begin
            {rg, rs} = 16'($random(seed));
            set_cfg(rg, rs, r[0], 3'(r));
            temp_delta = 8'($random(seed) % 32);
            repeat (6) begin
                sample(10'($random(seed)), $random(seed) % 8 == 0);
            end
        end
        overtemp_async = 1'b1;
        repeat (4) @(posedge clk);
        #1 chk_out({diag_error_q, dac_code_q}, 11'h400);
        overtemp_async = 1'b0;
        repeat (4) @(posedge clk);
        sample(10'h000, 1'b0);
        xfer(1'b1, A1, 16'h8000, 1'b1, 16'h8000);
        xfer(1'b1, A0, 16'h2000, 1'b1, 16'h2000);
        power_cycle();
        xfer(1'b1, A0, 16'h4000, 1'b0, 16'h4000);
        xfer(1'b1, A1, 16'h0000, 1'b0, 16'h0000);
        xfer(1'b0, A0, 16'h0000, 1'b1, 16'h2000);
        xfer(1'b0, A1, 16'h0000, 1'b1, 16'h8000);
        print_verdict();
    end
endmodule : field_sensor_conditioning_tb_top

// ### dv/fsc_programmer.sv
/* Programmer model: sends one telegram on the supply line, then reads
   the reply from the output pin. Assumes the core's telegram and reply
   format and a clock shared with the core. */
`timescale 1ns/10ps
module fsc_programmer #(
    parameter int BIT_CYCLES = 20
) (
    // Clock
    input  wire logic clk,
    // Link
    output logic      supply_program_line,
    input  wire logic reply_bit_q,
    input  wire logic reply_active_q
);
    logic [16:0] reply_q;
    logic        timed_out;

    initial supply_program_line = 1'b1;

    // Start bit, write flag, address, data, MSB first
    task automatic transfer(input logic wr, input logic [2:0] addr,
                            input logic [15:0] data);
        logic [20:0] frame;
        int          n;
        frame = {1'b0, wr, addr, data};
        for (int i = 20; i >= 0; i--) begin
            @(posedge clk);
            #1 supply_program_line = frame[i];
            repeat (BIT_CYCLES - 1) @(posedge clk);
        end
        @(posedge clk);
        #1 supply_program_line = 1'b1;
        n = 0;
        while (reply_active_q !== 1'b1 && n < 8 * BIT_CYCLES) begin
            @(posedge clk);
            #1 n++;
        end
        timed_out = n >= 8 * BIT_CYCLES;
        // Mid-bit sampling keeps clear of the reply's bit edges
        repeat (BIT_CYCLES / 2) @(posedge clk);
        for (int i = 16; i >= 0; i--) begin
            #1 reply_q[i] = reply_bit_q;
            repeat (BIT_CYCLES) @(posedge clk);
        end
        // Reply must be over after 17 bit times
        if (reply_active_q !== 1'b0) timed_out = 1'b1;
    endtask : transfer
endmodule : fsc_programmer

// ### hw/fsc_core.sv
/*
 * Field sensor conditioning core: signal path from A/D sample to D/A
 * code, customer nonvolatile registers with write protect, and the
 * command receiver on the supply line with its reply on the output pin.
 * Assumes: sys_rst marks a power cycle; the nonvolatile array keeps its
 * contents across it; A/D sample and temperature delta come from logic
 * on clk; supply line and overtemperature flag are asynchronous.
 */
`timescale 1ns/10ps
// Notes on behaviour
// - Sample passes gain, shift and temperature path and feeds the D/A code.
// - Set write protect refuses all link writes; only a factory write can clear the bit.
// - Supply-line telegram reads or writes memory; reply goes out on output pin.
// - Path or A/D overflow, or overtemperature, forces the diagnostic code.
// - Negative gain: south field raises output; positive gain inverts it.
// - Measured-value register is 16 bits, read only, 10 valid bits.
// - Measured value is signed, -512 to 511.
// - Gain 1: measured value rises for north (negative) fields.
// - Exactly four 16-bit customer nonvolatile registers.
// - First register holds 8-bit gain and 8-bit zero-field shift.
// - Gain spans -2 to 2 in steps of 1/64.
// - Gain 1, shift 0: sample 511 gives full-scale output; sample -512 overflows.
// - Zero-field shift feeds the adder and sets zero-field output.
// - Alignment 1: shift spans full scale; 0: one quarter.
// - Second register: protect, alignment, quad tempco, linear tempco, range.
// - Range select drives the A/D range, 20 mT per step.
// - Linear and quadratic tempco shape gain versus temperature.
// - Third and fourth registers hold production info, read only.
// - Protect acts after next power cycle; reads always answered.
// - Value equals minus gain times (sample minus shift), both 8-bit signed.
module fsc_core #(
    parameter int BIT_CYCLES = fsc_pkg::BIT_CYCLES
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               sys_rst,
    // Analog front end
    input  wire logic signed [9:0]  adc_sample,
    input  wire logic               adc_valid,
    input  wire logic               adc_overflow,
    input  wire logic signed [7:0]  temp_delta,
    input  wire logic               overtemp_async,
    output logic             [2:0]  adc_range_q,
    // D/A output stage
    output logic             [9:0]  dac_code_q,
    output logic                    diag_error_q,
    // Programming link
    input  wire logic               supply_program_line,
    output logic                    reply_bit_q,
    output logic                    reply_active_q,
    // Factory access, ignores write protect
    input  wire logic               factory_wr,
    input  wire logic        [1:0]  factory_addr,
    input  wire logic        [15:0] factory_data
);
    typedef enum logic [1:0] {FSC_IDLE, FSC_RECV, FSC_REPLY} fsc_state_e;

    function automatic logic fsc_in_range(input logic signed [35:0] v);
        return (v <= fsc_pkg::VAL_MAX) && (v >= fsc_pkg::VAL_MIN);
    endfunction : fsc_in_range

    // Nonvolatile array: no reset, it survives power cycles
    logic [15:0] nv_q [fsc_pkg::NV_REGS];
    logic        protect_live_q;
    logic        boot_q;
    logic [1:0]  line_sync_q;
    logic        line_prev_q;
    logic [1:0]  otemp_sync_q;
    fsc_state_e  state_q;
    logic [31:0] bit_tmr_q;
    logic [4:0]  bit_cnt_q;
    logic [19:0] rx_shift_q;
    logic [16:0] tx_shift_q;
    logic signed [9:0] meas_q;

    // Field views of the customer registers
    logic signed [7:0] gain;
    logic signed [7:0] shift;
    logic              align;
    logic signed [4:0] quad_tc;
    logic signed [4:0] lin_tc;
    assign gain    = nv_q[0][fsc_pkg::GAIN_LSB +: 8];
    assign shift   = nv_q[0][fsc_pkg::SHIFT_LSB +: 8];
    assign align   = nv_q[1][fsc_pkg::ALIGN_BIT];
    assign quad_tc = nv_q[1][fsc_pkg::QUAD_LSB +: 5];
    assign lin_tc  = nv_q[1][fsc_pkg::LIN_LSB +: 5];

    // Signal path, all in one cycle on adc_valid
    logic signed [11:0] shift_eff;
    logic signed [11:0] diff;
    logic signed [35:0] scaled;
    logic signed [35:0] gfac;
    logic signed [35:0] comp;
    logic               path_err;
    always_comb begin
        // Full-scale shift is the 8-bit value times four
        shift_eff = align ? {{2{shift[7]}}, shift, 2'b00}
                          : {{4{shift[7]}}, shift};
        diff   = 12'(adc_sample) - shift_eff;
        // Gain of 64 is unity: step 1/64 over -2..2
        scaled = (36'(gain) * 36'(diff)) >>> fsc_pkg::GAIN_FRAC;
        gfac   = (36'sd1 <<< fsc_pkg::TEMP_FRAC)
               + 36'(lin_tc) * 36'(temp_delta)
               + ((36'(quad_tc) * 36'(temp_delta) * 36'(temp_delta))
                  >>> fsc_pkg::QUAD_SHIFT);
        // Negated so a positive gain rises for north fields
        comp   = -((scaled * gfac) >>> fsc_pkg::TEMP_FRAC);
        path_err = !fsc_in_range(scaled) || !fsc_in_range(comp) ||
                   adc_overflow;
    end

    // Overtemperature flag crosses in through two flops
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            otemp_sync_q <= 2'b00;
        end else begin
            otemp_sync_q <= {otemp_sync_q[0], overtemp_async};
        end
    end

    // Output stage: measured value, D/A code, diagnostic band
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meas_q       <= 10'sh000;
            dac_code_q   <= fsc_pkg::DAC_MID;
            diag_error_q <= 1'b0;
        end else begin
            if (adc_valid) begin
                meas_q       <= comp[9:0];
                diag_error_q <= path_err || otemp_sync_q[1];
                if (path_err || otemp_sync_q[1]) begin
                    dac_code_q <= fsc_pkg::DIAG_CODE;
                end else begin
                    // Offset binary: 0 field sits at mid supply
                    dac_code_q <= comp[9:0] ^ fsc_pkg::DAC_MID;
                end
            end else if (otemp_sync_q[1]) begin
                diag_error_q <= 1'b1;
                dac_code_q   <= fsc_pkg::DIAG_CODE;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            adc_range_q <= 3'h0;
        end else begin
            adc_range_q <= nv_q[1][fsc_pkg::RANGE_LSB +: 3];
        end
    end

    // Protect is sampled once after power-up, so a new set waits
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            boot_q         <= 1'b1;
            protect_live_q <= 1'b1;
        end else begin
            boot_q <= 1'b0;
            if (boot_q) begin
                protect_live_q <= nv_q[1][fsc_pkg::PROTECT_BIT];
            end
        end
    end

    // Supply line synchroniser and edge memory
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_sync_q <= 2'b11;
            line_prev_q <= 1'b1;
        end else begin
            line_sync_q <= {line_sync_q[0], supply_program_line};
            line_prev_q <= line_sync_q[1];
        end
    end

    // Decoded command at the end of reception
    logic        cmd_write;
    logic [2:0]  cmd_addr;
    logic [15:0] cmd_data;
    logic        wr_ok;
    logic        bit_tick;
    logic        rx_done;
    logic [15:0] rd_data;
    assign cmd_write = rx_shift_q[19];
    assign cmd_addr  = rx_shift_q[18:16];
    assign cmd_data  = rx_shift_q[15:0];
    assign bit_tick  = (bit_tmr_q == 32'(BIT_CYCLES - 1));
    // Decode one bit time after the last data sample, once all
    // RX_BITS bits behind the start bit have been shifted in
    assign rx_done   = state_q == FSC_RECV && bit_tick &&
                       bit_cnt_q == 5'(fsc_pkg::RX_BITS + 1);
    // Only the two configuration registers take writes, and not once
    // protected; production words and measured value are read only
    assign wr_ok = !protect_live_q &&
                   (cmd_addr == fsc_pkg::REG_GAIN_SHIFT ||
                    cmd_addr == fsc_pkg::REG_RANGE_TC);
    always_comb begin
        case (cmd_addr)
            fsc_pkg::REG_GAIN_SHIFT: rd_data = nv_q[0];
            fsc_pkg::REG_RANGE_TC:   rd_data = nv_q[1];
            fsc_pkg::REG_PROD_LOW:   rd_data = nv_q[2];
            fsc_pkg::REG_PROD_HIGH:  rd_data = nv_q[3];
            fsc_pkg::REG_MEASURED:   rd_data = 16'(meas_q);
            default:                 rd_data = 16'h0000;
        endcase
    end

    // Telegram receiver and reply sequencer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q        <= FSC_IDLE;
            bit_tmr_q      <= 32'h0000_0000;
            bit_cnt_q      <= 5'h00;
            rx_shift_q     <= 20'h0_0000;
            tx_shift_q     <= 17'h0_0000;
            reply_bit_q    <= 1'b0;
            reply_active_q <= 1'b0;
        end else begin
            case (state_q)
                FSC_IDLE: begin
                    if (line_prev_q && !line_sync_q[1]) begin
                        // First sample lands mid-bit of the start bit
                        state_q   <= FSC_RECV;
                        bit_tmr_q <= 32'(BIT_CYCLES / 2);
                        bit_cnt_q <= 5'h00;
                    end
                end
                FSC_RECV: begin
                    bit_tmr_q <= bit_tick ? 32'h0 : bit_tmr_q + 32'h1;
                    if (bit_tick) begin
                        if (bit_cnt_q == 5'h00 && line_sync_q[1]) begin
                            state_q <= FSC_IDLE;         // Glitch, no start
                        end else if (rx_done) begin
                            state_q <= FSC_REPLY;
                            bit_cnt_q <= 5'h00;
                            tx_shift_q <= {!cmd_write || wr_ok,
                                cmd_write ? cmd_data : rd_data};
                        end else begin
                            bit_cnt_q <= bit_cnt_q + 5'h01;
                            if (bit_cnt_q != 5'h00) begin
                                rx_shift_q <= {rx_shift_q[18:0],
                                               line_sync_q[1]};
                            end
                        end
                    end
                end
                FSC_REPLY: begin
                    bit_tmr_q <= bit_tick ? 32'h0 : bit_tmr_q + 32'h1;
                    if (bit_tmr_q == 32'h0) begin
                        if (bit_cnt_q == 5'(fsc_pkg::TX_BITS)) begin
                            state_q        <= FSC_IDLE;
                            reply_active_q <= 1'b0;
                            reply_bit_q    <= 1'b0;
                        end else begin
                            reply_active_q <= 1'b1;
                            reply_bit_q    <= tx_shift_q[16];
                            tx_shift_q     <= {tx_shift_q[15:0], 1'b0};
                            bit_cnt_q      <= bit_cnt_q + 5'h01;
                        end
                    end
                end
                default: state_q <= FSC_IDLE;
            endcase
        end
    end

    // Nonvolatile writes; a link write only ever sets the protect bit
    logic link_wr;
    assign link_wr = rx_done && cmd_write && wr_ok;
    always_ff @(posedge clk) begin
        if (factory_wr) begin
            nv_q[factory_addr] <= factory_data;
        end else if (link_wr) begin
            if (cmd_addr == fsc_pkg::REG_RANGE_TC) begin
                nv_q[1] <= (cmd_data & fsc_pkg::RANGE_TC_WMASK) |
                    (nv_q[1] & (16'h0001 << fsc_pkg::PROTECT_BIT));
            end else begin
                nv_q[0] <= cmd_data;
            end
        end
    end

    default clocking fsc_cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    diag_on_error_a: assert property (
        adc_valid && (path_err || otemp_sync_q[1]) |=>
            dac_code_q == fsc_pkg::DIAG_CODE && diag_error_q)
        else $error("error did not force diagnostic code");
    dac_tracks_meas_a: assert property (
        adc_valid && !path_err && !otemp_sync_q[1] |=>
            dac_code_q == ($past(comp[9:0]) ^ fsc_pkg::DAC_MID))
        else $error("D/A code does not follow processed value");
    meas_in_range_a: assert property (
        adc_valid && !path_err |=> 36'(meas_q) == $past(comp))
        else $error("measured value lost bits of the result");
    protect_blocks_a: assert property (
        protect_live_q && !factory_wr |=> $stable(nv_q[0]) &&
            $stable(nv_q[1]))
        else $error("write accepted while protected");
    protect_sticky_a: assert property (
        nv_q[1][fsc_pkg::PROTECT_BIT] && !factory_wr |=>
            nv_q[1][fsc_pkg::PROTECT_BIT])
        else $error("protect bit cleared");
    protect_boot_a: assert property (
        !boot_q |=> protect_live_q == $past(protect_live_q))
        else $error("protect changed without power cycle");
    range_follows_a: assert property (
        ##1 adc_range_q == $past(nv_q[1][fsc_pkg::RANGE_LSB +: 3]))
        else $error("A/D range does not follow register");
    reply_length_a: assert property (
        $rose(reply_active_q) |-> reply_active_q [*8])
        else $error("reply ended early");
    prod_read_only_a: assert property (
        !factory_wr |=> $stable(nv_q[2]) && $stable(nv_q[3]))
        else $error("production word changed");

    // Link decode, reply framing, the protect latch and the diagnostic flag
    refused_ack_a: assert property (
        rx_done && cmd_write &&
            (protect_live_q || cmd_addr > fsc_pkg::REG_RANGE_TC)
            |=> !tx_shift_q[16])
        else $error("refused write was acknowledged");
    read_ack_a: assert property (
        rx_done && !cmd_write |=> tx_shift_q[16] &&
            tx_shift_q[15:0] == $past(rd_data))
        else $error("read not answered with register data");
    write_lands_a: assert property (
        rx_done && cmd_write && !protect_live_q && !factory_wr &&
            cmd_addr == fsc_pkg::REG_GAIN_SHIFT |=>
            nv_q[0] == $past(cmd_data))
        else $error("accepted write did not land");
    boot_latch_a: assert property (
        boot_q |=> protect_live_q == $past(nv_q[1][fsc_pkg::PROTECT_BIT]))
        else $error("protect not taken from register at power-up");
    overtemp_forces_a: assert property (
        otemp_sync_q[1] |=> dac_code_q == fsc_pkg::DIAG_CODE && diag_error_q)
        else $error("overtemperature did not force diagnostic code");
    diag_clears_a: assert property (
        adc_valid && !path_err && !otemp_sync_q[1] |=> !diag_error_q)
        else $error("diagnostic flag stuck after a clean sample");
    reply_idle_low_a: assert property (
        !reply_active_q |-> !reply_bit_q)
        else $error("reply bit driven outside a reply");
    reply_ends_idle_a: assert property (
        $fell(reply_active_q) |-> state_q == FSC_IDLE)
        else $error("reply ended without returning to idle");
endmodule : fsc_core

// ### include/fsc_pkg.sv
/*
 * Shared constants of the field sensor conditioning core: register
 * indices, field layouts, telegram format and timing.
 * Assumes a 100 MHz core clock and a 10-bit signed A/D sample.
 */
package fsc_pkg;
    // Clock and telegram bit time
    localparam int CLK_PERIOD_NS = 10;
    localparam int BIT_TIME_NS   = 100000;
    localparam int BIT_CYCLES    = BIT_TIME_NS / CLK_PERIOD_NS;

    // Register indices carried in the 3-bit telegram address
    localparam logic [2:0] REG_GAIN_SHIFT = 3'h0;
    localparam logic [2:0] REG_RANGE_TC   = 3'h1;
    localparam logic [2:0] REG_PROD_LOW   = 3'h2;
    localparam logic [2:0] REG_PROD_HIGH  = 3'h3;
    localparam logic [2:0] REG_MEASURED   = 3'h4;
    localparam int         NV_REGS        = 4;

    // gain_and_shift_config fields
    localparam int GAIN_LSB  = 8;
    localparam int SHIFT_LSB = 0;
    // range_tempco_protect_config fields
    localparam int PROTECT_BIT = 15;
    localparam int ALIGN_BIT   = 14;
    localparam int QUAD_LSB    = 9;
    localparam int LIN_LSB     = 4;
    localparam int RANGE_LSB   = 0;
    localparam logic [15:0] RANGE_TC_WMASK = 16'hFFF7;

    // Telegram: start, write flag, 3 address bits, 16 data bits
    localparam int RX_BITS = 20;
    // Reply: accept flag, then 16 data bits MSB first
    localparam int TX_BITS = 17;

    // Signal path scaling
    localparam int GAIN_FRAC  = 6;
    localparam int TEMP_FRAC  = 10;
    localparam int QUAD_SHIFT = 8;
    localparam logic [9:0]  DAC_MID   = 10'h200;
    localparam logic [9:0]  DIAG_CODE = 10'h000;
    localparam logic signed [35:0] VAL_MAX = 36'sh0_0000_01FF;
    localparam logic signed [35:0] VAL_MIN = -36'sh0_0000_0200;
endpackage : fsc_pkg
